/* File: design/acr_pkg.sv */
/*
  shared constants, types and register map for the converter control block.
  assumes a single 250 MHz system clock and an indirect module access port.
*/
// Overview of operation
// - after reset registers read 0000h; three bias/reference registers read 0070h
// - command bits 11-8 pick source; bit 2, 1, 0 start ch1, ch2, temperature
// - a start bit converts with its source settings into its own result register
// - processor is held stalled while any conversion runs
// - all three start bits 2-0 clear when a conversion completes
// - with source 0000, ch1 start wins and converts the ch1 differential pair
// - with source 0000, ch2 start without ch1 converts the ch2 pair
// - temperature converts only alone with source 0000; otherwise no result
// - nonzero source with ch1/ch2 start converts single-ended into that channel
// - source codes 0001 to 1001 select bandgap, amplifiers, supply, ground, DAC, pins
// - source codes 0100 to 0111 force a fixed 0.7 front-end gain
// - gain/timing register: gain 15-11, divider 10-8, resolution 6-4, bit 7 unused
// - coarse offset: bit 3 sign, bits 2-0 magnitude
// - bias/reference register: bias 6-4, reference 1-0, other bits unused
// - result registers are read-only, written only by a finished conversion
package acr_pkg;

    localparam int NSRC = 3;

    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [NSRC-1:0][7:0] ADDR_RESULT = {8'h07, 8'h04, 8'h01};
    localparam logic [NSRC-1:0][7:0] ADDR_GT = {8'h08, 8'h05, 8'h02};
    localparam logic [NSRC-1:0][7:0] ADDR_BR = {8'h09, 8'h06, 8'h03};

    localparam logic [15:0] RST_CMD = 16'h0000;
    localparam logic [15:0] RST_RESULT = 16'h0000;
    localparam logic [15:0] RST_GT = 16'h0000;
    localparam logic [15:0] RST_BR = 16'h0070;

    localparam logic [15:0] MASK_CMD = 16'h0f07;
    localparam logic [15:0] MASK_GT = 16'hff7f;
    localparam logic [15:0] MASK_BR = 16'h0073;

    localparam int CMD_SE_LSB = 8;
    localparam int CMD_CH1 = 2;
    localparam int CMD_CH2 = 1;
    localparam int CMD_TEMP = 0;
    localparam int GT_GAIN_LSB = 11;
    localparam int GT_DIV_LSB = 8;
    localparam int GT_RES_LSB = 4;
    localparam int GT_OFS_SIGN = 3;
    localparam int GT_OFS_LSB = 0;
    localparam int BR_BIAS_LSB = 4;
    localparam int BR_REF_LSB = 0;

    localparam logic [1:0] SRC_CH1 = 2'h0;
    localparam logic [1:0] SRC_CH2 = 2'h1;
    localparam logic [1:0] SRC_TEMP = 2'h2;

    localparam logic [3:0] SE_DIFF = 4'h0;
    localparam logic [3:0] SE_BANDGAP = 4'h1;
    localparam logic [3:0] SE_AMP_SMALL = 4'h2;
    localparam logic [3:0] SE_AMP_LARGE = 4'h3;
    localparam logic [3:0] SE_SUPPLY = 4'h4;
    localparam logic [3:0] SE_GROUND = 4'h5;
    localparam logic [3:0] SE_DAC_SMALL = 4'h6;
    localparam logic [3:0] SE_DAC_LARGE = 4'h7;
    localparam logic [3:0] SE_PIN_POS = 4'h8;
    localparam logic [3:0] SE_PIN_NEG = 4'h9;

    // converter base clock period and system clock period
    localparam int FCLK_PERIOD_PS = 250000;
    localparam int SYS_PERIOD_PS = 4000;
    localparam int FCLK_CYCLES = (FCLK_PERIOD_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
    localparam int DIV_BASE_SHIFT = 2;
    // converter clocks per conversion by resolution code
    localparam logic [7:0][11:0] RES_CLOCKS = {12'h800, 12'h800, 12'h500, 12'h320,
                                               12'h280, 12'h200, 12'h140, 12'h100};

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } acr_state_t;

    typedef struct packed
    {
        logic active;
        logic [1:0] source;
        logic single_ended;
        logic [3:0] input_mux_choice;
        logic fixed_gain;
        logic [4:0] gain_code;
        logic [2:0] conversion_divider;
        logic [2:0] resolution_code;
        logic offset_sign;
        logic [2:0] offset_magnitude;
        logic [2:0] bias_setting;
        logic [1:0] reference_choice;
    } acr_fe_t;

    typedef struct packed
    {
        acr_state_t state;
        logic [15:0] cmd;
        logic [NSRC-1:0][15:0] result;
        logic [NSRC-1:0][15:0] gt;
        logic [NSRC-1:0][15:0] br;
        acr_fe_t fe;
        logic [6:0] tick;
        logic [20:0] remain;
        logic [15:0] rdata;
        logic ack;
    } acr_state_reg_t;

endpackage

/* File: design/acr_top.sv */
/*
  converter control register bank and conversion sequencer.
  assumes the processor issues one module transfer at a time and the
  analog front end presents its sample on i_adc_sample at completion.
*/
`timescale 1ns/100ps
module acr_top
#(
    parameter logic [6:0] FCLK_CYCLES = 7'(acr_pkg::FCLK_CYCLES)
)
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_mod_req,
    input wire logic i_mod_rd,
    input wire logic [7:0] i_mod_addr,
    input wire logic [15:0] i_mod_wdata,
    input wire logic [15:0] i_adc_sample,
    output logic o_mod_ack,
    output logic [15:0] o_mod_rdata,
    output logic o_cpu_stall,
    output acr_pkg::acr_fe_t o_fe
);

    acr_pkg::acr_state_reg_t s_q;
    acr_pkg::acr_state_reg_t s_d;
    logic [15:0] rd_val;
    logic [3:0] se_w;
    logic [2:0] start_w;
    logic go;
    logic [1:0] src;

    // read decode
    always_comb
    begin
        rd_val = 16'h0000;
        if (i_mod_addr == acr_pkg::ADDR_CMD)
        begin
            rd_val = s_q.cmd;
        end
        for (int k = 0; k < acr_pkg::NSRC; k++)
        begin
            if (i_mod_addr == acr_pkg::ADDR_RESULT[k])
            begin
                rd_val = s_q.result[k];
            end
            if (i_mod_addr == acr_pkg::ADDR_GT[k])
            begin
                rd_val = s_q.gt[k];
            end
            if (i_mod_addr == acr_pkg::ADDR_BR[k])
            begin
                rd_val = s_q.br[k];
            end
        end
    end

    // start arbitration
    always_comb
    begin
        se_w = i_mod_wdata[acr_pkg::CMD_SE_LSB +: 4];
        start_w = i_mod_wdata[2:0];
        go = 1'b0;
        src = acr_pkg::SRC_CH1;
        if (start_w[acr_pkg::CMD_CH1])
        begin
            go = 1'b1;
            src = acr_pkg::SRC_CH1;
        end
        else if (start_w[acr_pkg::CMD_CH2])
        begin
            go = 1'b1;
            src = acr_pkg::SRC_CH2;
        end
        else if (start_w[acr_pkg::CMD_TEMP] && se_w == acr_pkg::SE_DIFF)
        begin
            go = 1'b1;
            src = acr_pkg::SRC_TEMP;
        end
    end

    always_comb
    begin
        s_d = s_q;
        s_d.ack = 1'b0;
        unique case (s_q.state)
            acr_pkg::ST_IDLE:
            begin
                if (i_mod_req)
                begin
                    s_d.ack = 1'b1;
                    if (i_mod_rd)
                    begin
                        s_d.rdata = rd_val;
                    end
                    else
                    begin
                        if (i_mod_addr == acr_pkg::ADDR_CMD)
                        begin
                            s_d.cmd = i_mod_wdata & acr_pkg::MASK_CMD;
                        end
                        for (int k = 0; k < acr_pkg::NSRC; k++)
                        begin
                            if (i_mod_addr == acr_pkg::ADDR_GT[k])
                            begin
                                s_d.gt[k] = i_mod_wdata & acr_pkg::MASK_GT;
                            end
                            if (i_mod_addr == acr_pkg::ADDR_BR[k])
                            begin
                                s_d.br[k] = i_mod_wdata & acr_pkg::MASK_BR;
                            end
                        end
                        if (i_mod_addr == acr_pkg::ADDR_CMD)
                        begin
                            if (go)
                            begin
                                s_d.state = acr_pkg::ST_RUN;
                                s_d.fe.active = 1'b1;
                                s_d.fe.source = src;
                                s_d.fe.single_ended = se_w != acr_pkg::SE_DIFF;
                                s_d.fe.input_mux_choice = se_w;
                                s_d.fe.fixed_gain = se_w >= acr_pkg::SE_SUPPLY && se_w <= acr_pkg::SE_DAC_LARGE;
                                s_d.fe.gain_code = s_q.gt[src][acr_pkg::GT_GAIN_LSB +: 5];
                                s_d.fe.conversion_divider = s_q.gt[src][acr_pkg::GT_DIV_LSB +: 3];
                                s_d.fe.resolution_code = s_q.gt[src][acr_pkg::GT_RES_LSB +: 3];
                                s_d.fe.offset_sign = s_q.gt[src][acr_pkg::GT_OFS_SIGN];
                                s_d.fe.offset_magnitude = s_q.gt[src][acr_pkg::GT_OFS_LSB +: 3];
                                s_d.fe.bias_setting = s_q.br[src][acr_pkg::BR_BIAS_LSB +: 3];
                                s_d.fe.reference_choice = s_q.br[src][acr_pkg::BR_REF_LSB +: 2];
                                s_d.remain = 21'(acr_pkg::RES_CLOCKS[s_q.gt[src][acr_pkg::GT_RES_LSB +: 3]])
                                    << ({1'b0, s_q.gt[src][acr_pkg::GT_DIV_LSB +: 3]} + 4'(acr_pkg::DIV_BASE_SHIFT));
                                s_d.tick = 7'h00;
                            end
                            else
                            begin
                                s_d.cmd[2:0] = 3'h0;
                            end
                        end
                    end
                end
            end
            acr_pkg::ST_RUN:
            begin
                if (s_q.tick == FCLK_CYCLES - 7'h01)
                begin
                    s_d.tick = 7'h00;
                    if (s_q.remain == 21'h000001)
                    begin
                        s_d.result[s_q.fe.source] = i_adc_sample;
                        s_d.cmd[2:0] = 3'h0;
                        s_d.fe.active = 1'b0;
                        s_d.state = acr_pkg::ST_IDLE;
                    end
                    else
                    begin
                        s_d.remain = s_q.remain - 21'h000001;
                    end
                end
                else
                begin
                    s_d.tick = s_q.tick + 7'h01;
                end
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s_q <= '0;
            s_q.state <= acr_pkg::ST_IDLE;
            s_q.cmd <= acr_pkg::RST_CMD;
            s_q.result <= {acr_pkg::NSRC{acr_pkg::RST_RESULT}};
            s_q.gt <= {acr_pkg::NSRC{acr_pkg::RST_GT}};
            s_q.br <= {acr_pkg::NSRC{acr_pkg::RST_BR}};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_mod_ack = s_q.ack;
    assign o_mod_rdata = s_q.rdata;
    assign o_cpu_stall = s_q.state == acr_pkg::ST_RUN;
    assign o_fe = s_q.fe;

endmodule

/* File: test/acr_top_properties.sv */
/* port assertions for the converter control block.
   bound to acr_top; one clock, async active-low reset. */
`timescale 1ns/100ps
module acr_top_properties
#(
    parameter logic [6:0] FCLK_CYCLES = 7'h01
)
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_mod_req,
    input wire logic i_mod_rd,
    input wire logic [7:0] i_mod_addr,
    input wire logic [15:0] i_mod_wdata,
    input wire logic o_mod_ack,
    input wire logic o_cpu_stall,
    input wire acr_pkg::acr_fe_t o_fe
);
    logic take;
    logic wcmd;
    logic [3:0] mux;
    assign take = i_mod_req && !o_cpu_stall;
    assign wcmd = take && !i_mod_rd && i_mod_addr == acr_pkg::ADDR_CMD;
    assign mux = i_mod_wdata[11:8];
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_nrst);
    property p_ack; take |=> o_mod_ack; endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");
    property p_refuse; !take |=> !o_mod_ack; endproperty
    a_refuse: assert property (p_refuse) else $error("ack without accepted request");
    property p_stall; wcmd && |i_mod_wdata[2:1] |=> o_cpu_stall [*8]; endproperty
    a_stall: assert property (p_stall) else $error("stall not held");
    property p_prio1; wcmd && i_mod_wdata[2] |=> o_fe.active && o_fe.source == acr_pkg::SRC_CH1; endproperty
    a_prio1: assert property (p_prio1) else $error("channel one not chosen");
    property p_prio2; wcmd && i_mod_wdata[2:1] == 2'h1 |=> o_fe.source == acr_pkg::SRC_CH2; endproperty
    a_prio2: assert property (p_prio2) else $error("channel two not chosen");
    property p_tnone; wcmd && i_mod_wdata[2:0] == 3'h1 && mux != 4'h0 |=> !o_cpu_stall; endproperty
    a_tnone: assert property (p_tnone) else $error("temperature ran with source set");
    property p_temp; wcmd && i_mod_wdata[2:0] == 3'h1 && mux == 4'h0 |=> o_fe.source == acr_pkg::SRC_TEMP; endproperty
    a_temp: assert property (p_temp) else $error("temperature not chosen");
    property p_mux; wcmd && |i_mod_wdata[2:1] |=> o_fe.input_mux_choice == $past(mux); endproperty
    a_mux: assert property (p_mux) else $error("source code not routed");
    property p_se; o_fe.active |-> o_fe.single_ended == (o_fe.input_mux_choice != 4'h0); endproperty
    a_se: assert property (p_se) else $error("single-ended flag wrong");
    property p_gain; o_fe.active |-> o_fe.fixed_gain == (o_fe.input_mux_choice inside {[4'h4:4'h7]}); endproperty
    a_gain: assert property (p_gain) else $error("fixed gain flag wrong");
endmodule
bind acr_top acr_top_properties #(.FCLK_CYCLES(FCLK_CYCLES)) i_acr_top_properties (.i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst), .i_mod_req(i_mod_req), .i_mod_rd(i_mod_rd), .i_mod_addr(i_mod_addr),
    .i_mod_wdata(i_mod_wdata), .o_mod_ack(o_mod_ack), .o_cpu_stall(o_cpu_stall), .o_fe(o_fe));

/* File: test/acr_fe_model.sv */
/* analog front-end stand-in: sample encodes the routed settings.
   assumes settings stand for the whole conversion. */
`timescale 1ns/100ps
module acr_fe_model
(
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire acr_pkg::acr_fe_t i_fe,
    output logic [15:0] o_sample
);
    logic [15:0] idle_q;
    // idle pattern changes every cycle
    always_ff @(posedge i_clk_sys or negedge i_nrst)
        if (!i_nrst)
            idle_q <= 16'h0000;
        else
            idle_q <= ~idle_q + 16'h1357;
    assign o_sample = i_fe.active ? {i_fe.source, i_fe.input_mux_choice, i_fe.fixed_gain, i_fe.resolution_code,
        i_fe.conversion_divider, i_fe.reference_choice, i_fe.single_ended} : idle_q;
endmodule

/* File: test/acr_top_tb.sv */
/* self-checking bench for the converter control block.
   drives the module access port; front-end model supplies samples. */
`timescale 1ns/100ps
module acr_top_tb;
    logic i_clk_sys = 1'b0;
    logic i_nrst = 1'b0;
    logic i_mod_req = 1'b0;
    logic i_mod_rd = 1'b0;
    logic [7:0] i_mod_addr = 8'h00;
    logic [15:0] i_mod_wdata = 16'h0000;
    logic [15:0] sample;
    logic o_mod_ack;
    logic [15:0] o_mod_rdata;
    logic o_cpu_stall;
    acr_pkg::acr_fe_t o_fe;
    logic ack_seen;
    logic [15:0] rd_seen;
    logic [2:0][15:0] res_exp;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    localparam logic [2:0][15:0] GT = {16'h010f, 16'h081c, 16'h8003};
    localparam logic [2:0][15:0] BR = {16'h0063, 16'h0021, 16'h0052};
    localparam logic [2:0][15:0] LEN = {16'h0800, 16'h0500, 16'h0400};
    always #2 i_clk_sys = ~i_clk_sys;
    acr_top #(.FCLK_CYCLES(7'h01)) i_acr_top (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_mod_req(i_mod_req),
        .i_mod_rd(i_mod_rd), .i_mod_addr(i_mod_addr), .i_mod_wdata(i_mod_wdata), .i_adc_sample(sample),
        .o_mod_ack(o_mod_ack), .o_mod_rdata(o_mod_rdata), .o_cpu_stall(o_cpu_stall), .o_fe(o_fe));
    acr_fe_model i_acr_fe_model (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_fe(o_fe), .o_sample(sample));
    task automatic print_verdict;
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic rd, input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        #1;
        i_mod_req = 1'b1;
        i_mod_rd = rd;
        i_mod_addr = a;
        i_mod_wdata = d;
        @(posedge i_clk_sys);
        #1;
        i_mod_req = 1'b0;
        ack_seen = o_mod_ack;
        rd_seen = o_mod_rdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        xfer(1'b1, a, 16'h0000);
        chk({15'h0000, ack_seen}, 16'h0001);
        chk(rd_seen, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        xfer(1'b0, a, d);
        chk({15'h0000, ack_seen}, 16'h0001);
    endtask
    task automatic conv(input logic [15:0] cmd, input int src);
        int n;
        logic [3:0] m;
        n = 2;
        m = cmd[11:8];
        wr(8'h00, cmd);
        chk({3'h0, o_fe.gain_code, o_fe.offset_sign, o_fe.offset_magnitude, o_fe.bias_setting, o_fe.active},
            {3'h0, GT[src][15:11], GT[src][3], GT[src][2:0], BR[src][6:4], 1'b1});
        xfer(1'b0, 8'h00, 16'h0000);
        chk({15'h0000, ack_seen}, 16'h0000);
        while (o_cpu_stall === 1'b1 && n < 5000)
        begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        chk(n[15:0], LEN[src]);
        res_exp[src] = {src[1:0], m, m inside {[4'h4:4'h7]}, GT[src][6:4], GT[src][10:8], BR[src][1:0], m != 4'h0};
        for (int i = 0; i < 3; i++)
            rd(acr_pkg::ADDR_RESULT[i], res_exp[i]);
        rd(8'h00, {4'h0, m, 8'h00});
    endtask
    always @(posedge i_clk_sys)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_mismatch++;
            print_verdict;
        end
    end
    initial
    begin
        repeat (16) @(posedge i_clk_sys);
        #1;
        i_nrst = 1'b1;
        for (int a = 0; a < 11; a++)
            rd(a[7:0], (a % 3 == 0 && a > 0 && a < 10) ? 16'h0070 : 16'h0000);
        for (int s = 0; s < 3; s++)
        begin
            wr(acr_pkg::ADDR_GT[s], 16'hffff);
            wr(acr_pkg::ADDR_BR[s], 16'hffff);
            wr(acr_pkg::ADDR_RESULT[s], 16'hffff);
            rd(acr_pkg::ADDR_GT[s], 16'hff7f);
            rd(acr_pkg::ADDR_BR[s], 16'h0073);
            rd(acr_pkg::ADDR_RESULT[s], 16'h0000);
            wr(acr_pkg::ADDR_GT[s], GT[s]);
            wr(acr_pkg::ADDR_BR[s], BR[s]);
            res_exp[s] = 16'h0000;
        end
        wr(8'h00, 16'hf6f8);
        rd(8'h00, 16'h0600);
        wr(8'h0a, 16'h1234);
        rd(8'h0a, 16'h0000);
        wr(8'h00, 16'h0101);
        rd(8'h00, 16'h0100);
        conv(16'h0007, 0);
        conv(16'h0003, 1);
        conv(16'h0001, 2);
        for (int m = 1; m < 10; m++)
            conv({4'h0, m[3:0], 8'h00} | ((m % 2) ? 16'h0004 : 16'h0002), (m % 2) ? 0 : 1);
        print_verdict;
    end
endmodule
